// ---- shared/mpo_regs.vh ----
// Object index map, field limits, reset values and timing counts for the pulse output block
`ifndef MPO_REGS_VH
`define MPO_REGS_VH

// ************************************************************
// Object indices
// ************************************************************
`define MPO_IDX_MODE 16'h2004
`define MPO_IDX_START 16'h3100
`define MPO_IDX_COUNT 16'h3101
`define MPO_IDX_FREQ 16'h3102
`define MPO_IDX_DUTY 16'h3103
`define MPO_IDX_TRIG 16'h3104
`define MPO_IDX_SYNC_SEL 16'h3105
`define MPO_IDX_SYNC_GO 16'h3106

// ************************************************************
// Sizes and sub-index limits
// ************************************************************
`define MPO_NUM_CH 4
`define MPO_MAX_SUB_CH 8'h04
`define MPO_MAX_SUB_MOD 8'h01
`define MPO_MAX_SUB_MODE 8'h01

// ************************************************************
// Field values
// ************************************************************
`define MPO_MODE_BURST 8'h00
`define MPO_MODE_CONT 8'h01
`define MPO_FREQ_MIN 32'h0000_0064
`define MPO_FREQ_MAX 32'h004C_4B40
`define MPO_DUTY_MIN 16'h0001
`define MPO_DUTY_MAX 16'h03E7
`define MPO_DUTY_FULL 32'h0000_03E8

// ************************************************************
// Reset values
// ************************************************************
`define MPO_RST_COUNT 16'h0001
`define MPO_RST_FREQ 32'h0000_2710
`define MPO_RST_DUTY 16'h01F4
`define MPO_RST_PER 24'hFF_FFFF
`define MPO_RST_HI 24'h00_0001

// ************************************************************
// Timing: clock rate in Hz, frequency unit is 0.1 Hz
// ************************************************************
`define MPO_CLK_HZ 40'h00_0773_5940
`define MPO_FREQ_STEPS_PER_HZ 40'h00_0000_000A
`define MPO_PER_DIVIDEND (`MPO_CLK_HZ * `MPO_FREQ_STEPS_PER_HZ)
`define MPO_DIV_STEPS 6'h28

`endif

// ---- verilog/mpo_chan.v ----
// One pulse channel: period and high-time divider plus the pulse sequencer
`timescale 1ns/1ps
`default_nettype none
`include "mpo_regs.vh"

module mpo_chan (
  input wire clk,
  input wire rst_n,
  input wire [31:0] freq,
  input wire [15:0] duty,
  input wire [15:0] burst_count,
  input wire burst_mode,
  input wire en,
  input wire kick,
  output reg pwm_reg,
  output reg done_reg,
  output reg active_reg
);

  // ************************************************************
  // Divider: period = clock*10/freq, then high = period*duty/1000
  // ************************************************************
  localparam D_IDLE = 3'b001;
  localparam D_PER = 3'b010;
  localparam D_HI = 3'b100;

  reg [2:0] dstate_reg;
  reg [39:0] dvd_reg;
  reg [32:0] rem_reg;
  reg [31:0] dsor_reg;
  reg [5:0] step_reg;
  reg [15:0] duty_snap_reg;
  reg [23:0] per_calc_reg;
  reg [23:0] hi_calc_reg;

  wire [32:0] trial = {rem_reg[31:0], dvd_reg[39]} - {1'b0, dsor_reg};
  wire fits = ~trial[32];
  wire [39:0] quo = {dvd_reg[38:0], fits};
  // Saturate so a zero or tiny frequency never wraps the period
  wire [23:0] per_res = (|quo[39:24]) ? `MPO_RST_PER : quo[23:0];
  wire [15:0] duty_clamp = (duty < `MPO_DUTY_MIN) ? `MPO_DUTY_MIN :
                           (duty > `MPO_DUTY_MAX) ? `MPO_DUTY_MAX : duty;
  wire [39:0] hi_prod = per_res * duty_snap_reg;

  // Recompute continuously so new settings are ready by the next boundary
  always @(posedge clk) begin
    if (!rst_n) begin
      dstate_reg <= D_IDLE;
      dvd_reg <= 40'h00_0000_0000;
      rem_reg <= 33'h0_0000_0000;
      dsor_reg <= 32'h0000_0000;
      step_reg <= 6'h00;
      duty_snap_reg <= `MPO_RST_DUTY;
      per_calc_reg <= `MPO_RST_PER;
      hi_calc_reg <= `MPO_RST_HI;
    end else begin
      case (dstate_reg)
        D_IDLE: begin
          dvd_reg <= `MPO_PER_DIVIDEND;
          dsor_reg <= freq;
          duty_snap_reg <= duty_clamp;
          rem_reg <= 33'h0_0000_0000;
          step_reg <= `MPO_DIV_STEPS;
          dstate_reg <= D_PER;
        end
        D_PER, D_HI: begin
          rem_reg <= fits ? trial : {rem_reg[31:0], dvd_reg[39]};
          dvd_reg <= quo;
          step_reg <= step_reg - 6'h01;
          if (step_reg == 6'h01) begin
            rem_reg <= 33'h0_0000_0000;
            step_reg <= `MPO_DIV_STEPS;
            if (dstate_reg == D_PER) begin
              per_calc_reg <= per_res;
              dvd_reg <= hi_prod;
              dsor_reg <= `MPO_DUTY_FULL;
              dstate_reg <= D_HI;
            end else begin
              // A high time of zero would lose the pulse entirely
              hi_calc_reg <= (quo[23:0] == 24'h00_0000) ? `MPO_RST_HI : quo[23:0];
              dstate_reg <= D_IDLE;
            end
          end
        end
        default: dstate_reg <= D_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Pulse sequencer
  // ************************************************************
  reg [23:0] cnt_reg;
  reg [23:0] per_use_reg;
  reg [23:0] hi_use_reg;
  reg [15:0] left_reg;
  reg finished_reg;

  wire boundary = (cnt_reg >= per_use_reg - 24'h00_0001);
  wire [23:0] cnt_inc = cnt_reg + 24'h00_0001;

  // A finished burst stays idle until enable drops or a new kick arrives
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 24'h00_0000;
      per_use_reg <= `MPO_RST_PER;
      hi_use_reg <= `MPO_RST_HI;
      left_reg <= 16'h0000;
      finished_reg <= 1'b0;
      active_reg <= 1'b0;
      pwm_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (!en) begin
        active_reg <= 1'b0;
        pwm_reg <= 1'b0;
        finished_reg <= 1'b0;
      end else if (kick || (!active_reg && !finished_reg)) begin
        // Phase zero: first rising edge on the cycle after the kick
        active_reg <= 1'b1;
        finished_reg <= 1'b0;
        cnt_reg <= 24'h00_0000;
        per_use_reg <= per_calc_reg;
        hi_use_reg <= hi_calc_reg;
        left_reg <= burst_count;
        pwm_reg <= 1'b1;
      end else if (active_reg) begin
        if (boundary) begin
          if (burst_mode && left_reg <= 16'h0001) begin
            active_reg <= 1'b0;
            finished_reg <= 1'b1;
            done_reg <= 1'b1;
            pwm_reg <= 1'b0;
          end else begin
            cnt_reg <= 24'h00_0000;
            per_use_reg <= per_calc_reg;
            hi_use_reg <= hi_calc_reg;
            if (burst_mode) begin
              left_reg <= left_reg - 16'h0001;
            end
            pwm_reg <= 1'b1;
          end
        end else begin
          cnt_reg <= cnt_inc;
          pwm_reg <= (cnt_inc < hi_use_reg);
        end
      end
    end
  end

endmodule // mpo_chan

`default_nettype wire

// ---- verilog/mpo_top.v ----
// Multichannel pulse output block with its object dictionary access port
//
// Contract
// - One start/stop entry per channel
// - Sub-index n controls channel n-1
// - Burst or continuous chosen by separate entry
// - Burst count 1..65535 held per channel
// - Start in burst mode emits exactly count pulses
// - Continuous mode runs until start cleared
// - Frequency in 0.1 Hz, 100..5000000
// - Duty per mille sets high time
// - Trigger enable repurposes input as trigger
// - Triggered channel runs while trigger asserted
// - Only sync-selected channels join sync start
// - Sync start aligns first rising edges
// - Sync start sub-index per module, slot order
// - Sub-index 0 reports largest sub-index, read-only
// - Only start entries mappable into process data; the sync start entry is accepted from process data as well
`timescale 1ns/1ps
`default_nettype none
`include "mpo_regs.vh"

module mpo_top (
  input wire CLK,
  input wire RST_N,
  input wire OD_WR,
  input wire OD_RD,
  input wire OD_PDO,
  input wire [15:0] OD_INDEX,
  input wire [7:0] OD_SUBIDX,
  input wire [31:0] OD_WDATA,
  input wire [3:0] TRIGGER_CAPABLE_INPUT,
  output reg [31:0] OD_RDATA,
  output reg OD_ACK,
  output reg OD_ERR,
  output wire [3:0] PULSE_OUT,
  output reg [3:0] INPUT_STATE
);

  // ************************************************************
  // Configuration storage
  // ************************************************************
  reg [3:0] start_reg;
  reg [3:0] trig_en_reg;
  reg [3:0] sync_sel_reg;
  reg sync_go_reg;
  reg mode_cont_reg;
  reg [15:0] count_mem [0:`MPO_NUM_CH-1];
  reg [31:0] freq_mem [0:`MPO_NUM_CH-1];
  reg [15:0] duty_mem [0:`MPO_NUM_CH-1];
  reg [3:0] kick_reg;

  wire [3:0] chan_done;
  wire [3:0] chan_active;
  wire [3:0] chan_pwm;

  // ************************************************************
  // Trigger input synchroniser
  // ************************************************************
  reg [3:0] trig_meta_reg;
  reg [3:0] trig_sync_reg;

  // Pins are asynchronous to CLK, two stages before any use
  always @(posedge CLK) begin
    if (!RST_N) begin
      trig_meta_reg <= 4'h0;
      trig_sync_reg <= 4'h0;
    end else begin
      trig_meta_reg <= TRIGGER_CAPABLE_INPUT;
      trig_sync_reg <= trig_meta_reg;
    end
  end

  // Repurposed inputs no longer show as plain inputs
  always @(posedge CLK) begin
    if (!RST_N) begin
      INPUT_STATE <= 4'h0;
    end else begin
      INPUT_STATE <= trig_sync_reg & ~trig_en_reg;
    end
  end

  // ************************************************************
  // Access decode
  // ************************************************************
  wire sub_zero = (OD_SUBIDX == 8'h00);
  wire sub_ch_ok = !sub_zero && (OD_SUBIDX <= `MPO_MAX_SUB_CH);
  wire sub_mod_ok = !sub_zero && (OD_SUBIDX <= `MPO_MAX_SUB_MOD);
  wire [1:0] ch_sel = OD_SUBIDX[1:0] - 2'h1;
  wire wbit_ok = (OD_WDATA[31:1] == 31'h0000_0000);
  wire is_ch_idx = (OD_INDEX >= `MPO_IDX_START) && (OD_INDEX <= `MPO_IDX_SYNC_SEL);
  wire is_mappable = (OD_INDEX == `MPO_IDX_START) || (OD_INDEX == `MPO_IDX_SYNC_GO);

  reg acc_err;
  reg [31:0] rd_val;

  // Error check and read mux for the addressed entry
  always @* begin
    acc_err = 1'b0;
    rd_val = 32'h0000_0000;
    if (OD_PDO && !is_mappable) begin
      acc_err = 1'b1;
    end else if (is_ch_idx) begin
      if (sub_zero) begin
        rd_val = {24'h00_0000, `MPO_MAX_SUB_CH};
        acc_err = OD_WR;
      end else if (!sub_ch_ok) begin
        acc_err = 1'b1;
      end else begin
        case (OD_INDEX)
          `MPO_IDX_START: begin
            rd_val = {31'h0000_0000, start_reg[ch_sel]};
            acc_err = OD_WR && !wbit_ok;
          end
          `MPO_IDX_COUNT: rd_val = {16'h0000, count_mem[ch_sel]};
          `MPO_IDX_FREQ: rd_val = freq_mem[ch_sel];
          `MPO_IDX_DUTY: rd_val = {16'h0000, duty_mem[ch_sel]};
          `MPO_IDX_TRIG: begin
            rd_val = {31'h0000_0000, trig_en_reg[ch_sel]};
            acc_err = OD_WR && !wbit_ok;
          end
          default: begin
            rd_val = {31'h0000_0000, sync_sel_reg[ch_sel]};
            acc_err = OD_WR && !wbit_ok;
          end
        endcase
      end
    end else if (OD_INDEX == `MPO_IDX_SYNC_GO) begin
      if (sub_zero) begin
        rd_val = {24'h00_0000, `MPO_MAX_SUB_MOD};
        acc_err = OD_WR;
      end else if (!sub_mod_ok) begin
        acc_err = 1'b1;
      end else begin
        rd_val = {31'h0000_0000, sync_go_reg};
        acc_err = OD_WR && !wbit_ok;
      end
    end else if (OD_INDEX == `MPO_IDX_MODE) begin
      if (sub_zero) begin
        rd_val = {24'h00_0000, `MPO_MAX_SUB_MODE};
        acc_err = OD_WR;
      end else if (OD_SUBIDX != `MPO_MAX_SUB_MODE) begin
        acc_err = 1'b1;
      end else begin
        rd_val = {31'h0000_0000, mode_cont_reg};
        acc_err = OD_WR && !wbit_ok;
      end
    end else begin
      acc_err = 1'b1;
    end
  end

  wire wr_ok = OD_WR && !acc_err;
  wire rd_take = OD_RD && !OD_WR;
  wire wr_start = wr_ok && (OD_INDEX == `MPO_IDX_START);
  wire sync_fire = wr_ok && (OD_INDEX == `MPO_IDX_SYNC_GO) && OD_WDATA[0];

  // ************************************************************
  // Answer to the access port
  // ************************************************************
  // One-cycle acknowledge on the edge after the strobe
  always @(posedge CLK) begin
    if (!RST_N) begin
      OD_ACK <= 1'b0;
      OD_ERR <= 1'b0;
      OD_RDATA <= 32'h0000_0000;
    end else begin
      OD_ACK <= OD_WR || OD_RD;
      OD_ERR <= (OD_WR || rd_take) && acc_err;
      OD_RDATA <= (rd_take && !acc_err) ? rd_val : 32'h0000_0000;
    end
  end

  // ************************************************************
  // Module-wide settings
  // ************************************************************
  // Sync start value is kept as written so a read shows the last request
  always @(posedge CLK) begin
    if (!RST_N) begin
      sync_go_reg <= 1'b0;
      mode_cont_reg <= 1'b0;
    end else begin
      if (wr_ok && OD_INDEX == `MPO_IDX_SYNC_GO) begin
        sync_go_reg <= OD_WDATA[0];
      end
      if (wr_ok && OD_INDEX == `MPO_IDX_MODE) begin
        mode_cont_reg <= OD_WDATA[0];
      end
    end
  end

  // ************************************************************
  // Per-channel control and pulse generators
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `MPO_NUM_CH; gi = gi + 1) begin : g_ch
      wire hit = (ch_sel == gi) && sub_ch_ok;
      wire join_sync = sync_fire && sync_sel_reg[gi];
      wire start_set = wr_start && hit && OD_WDATA[0];
      wire chan_en = trig_en_reg[gi] ? trig_sync_reg[gi] : start_reg[gi];

      // Writes and sync start win over the end-of-burst clear
      always @(posedge CLK) begin
        if (!RST_N) begin
          start_reg[gi] <= 1'b0;
          trig_en_reg[gi] <= 1'b0;
          sync_sel_reg[gi] <= 1'b0;
          kick_reg[gi] <= 1'b0;
        end else begin
          if (wr_start && hit) begin
            start_reg[gi] <= OD_WDATA[0];
          end else if (join_sync) begin
            start_reg[gi] <= 1'b1;
          end else if (chan_done[gi]) begin
            start_reg[gi] <= 1'b0;
          end
          // Kick rises on the same edge as the new start bit, one cycle after the write
          kick_reg[gi] <= start_set || join_sync;
          if (wr_ok && hit && OD_INDEX == `MPO_IDX_TRIG) begin
            trig_en_reg[gi] <= OD_WDATA[0];
          end
          if (wr_ok && hit && OD_INDEX == `MPO_IDX_SYNC_SEL) begin
            sync_sel_reg[gi] <= OD_WDATA[0];
          end
        end
      end

      // Numeric settings, range kept by the master
      always @(posedge CLK) begin
        if (!RST_N) begin
          count_mem[gi] <= `MPO_RST_COUNT;
          freq_mem[gi] <= `MPO_RST_FREQ;
          duty_mem[gi] <= `MPO_RST_DUTY;
        end else if (wr_ok && hit) begin
          if (OD_INDEX == `MPO_IDX_COUNT) begin
            count_mem[gi] <= OD_WDATA[15:0];
          end
          if (OD_INDEX == `MPO_IDX_FREQ) begin
            freq_mem[gi] <= OD_WDATA;
          end
          if (OD_INDEX == `MPO_IDX_DUTY) begin
            duty_mem[gi] <= OD_WDATA[15:0];
          end
        end
      end

      mpo_chan u_chan (
        .clk(CLK),
        .rst_n(RST_N),
        .freq(freq_mem[gi]),
        .duty(duty_mem[gi]),
        .burst_count(count_mem[gi]),
        .burst_mode(~mode_cont_reg),
        .en(chan_en),
        .kick(kick_reg[gi]),
        .pwm_reg(chan_pwm[gi]),
        .done_reg(chan_done[gi]),
        .active_reg(chan_active[gi])
      );
    end
  endgenerate

  // Pulse outputs come straight from the sequencer flops
  assign PULSE_OUT = chan_pwm;

endmodule // mpo_top

`default_nettype wire

// ---- testbench/mpo_sva.sv ----
// Checker for the access port of the pulse output block
`timescale 1ns/1ps
`default_nettype none

module mpo_sva (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic OD_WR,
  input wire logic OD_RD,
  input wire logic OD_PDO,
  input wire logic [15:0] OD_INDEX,
  input wire logic [7:0] OD_SUBIDX,
  input wire logic [31:0] OD_WDATA,
  input wire logic [31:0] OD_RDATA,
  input wire logic OD_ACK,
  input wire logic OD_ERR,
  input wire logic [3:0] PULSE_OUT
);
  // ************************************************************
  // Access checks
  // ************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Decoded request classes; a write wins over a read in the same cycle
  wire strobe = OD_WR | OD_RD;
  wire rd_only = OD_RD & ~OD_WR & ~OD_PDO;
  wire chan_idx = (OD_INDEX >= 16'h3100) && (OD_INDEX <= 16'h3105);

  ack_follows_a: assert property (strobe |=> OD_ACK)
    else $error("access not answered on next edge");
  ack_cause_a: assert property (OD_ACK |-> $past(strobe))
    else $error("answer without a request");
  start_value_a: assert property (OD_WR && OD_INDEX == 16'h3100
    && OD_WDATA > 32'h0000_0001 |=> OD_ERR)
    else $error("start value above one accepted");
  chan_range_a: assert property (strobe && chan_idx && OD_SUBIDX > 8'h04 |=> OD_ERR)
    else $error("channel sub-index beyond four accepted");
  sync_range_a: assert property (strobe && OD_INDEX == 16'h3106 && OD_SUBIDX > 8'h01
    |=> OD_ERR)
    else $error("module sub-index beyond one accepted");
  sub0_write_a: assert property (OD_WR && OD_SUBIDX == 8'h00 |=> OD_ERR)
    else $error("sub-index zero written");
  sub0_read_a: assert property (rd_only && chan_idx && OD_SUBIDX == 8'h00
    |=> !OD_ERR && OD_RDATA == 32'h0000_0004)
    else $error("channel entry count wrong");
  module_count_a: assert property (rd_only && OD_INDEX == 16'h3106
    && OD_SUBIDX == 8'h00 |=> !OD_ERR && OD_RDATA == 32'h0000_0001)
    else $error("module count wrong");
  pdo_filter_a: assert property (strobe && OD_PDO && OD_INDEX != 16'h3100
    && OD_INDEX != 16'h3106 |=> OD_ERR)
    else $error("process data reached a configuration entry");

  refused_c: cover property (OD_ACK && OD_ERR);
  pulse_c: cover property ($rose(PULSE_OUT[0]));
  aligned_c: cover property ($rose(PULSE_OUT[0]) && $rose(PULSE_OUT[2]));
endmodule // mpo_sva

bind mpo_top mpo_sva i_mpo_sva (.CLK(CLK), .RST_N(RST_N), .OD_WR(OD_WR), .OD_RD(OD_RD),
  .OD_PDO(OD_PDO), .OD_INDEX(OD_INDEX), .OD_SUBIDX(OD_SUBIDX), .OD_WDATA(OD_WDATA),
  .OD_RDATA(OD_RDATA), .OD_ACK(OD_ACK), .OD_ERR(OD_ERR), .PULSE_OUT(PULSE_OUT));
`default_nettype wire

// ---- testbench/mpo_master.sv ----
// Behavioural object dictionary master issuing single accesses
`timescale 1ns/1ps
`default_nettype none

module mpo_master (
  input wire logic clk,
  output var logic wr,
  output var logic rd,
  output var logic pdo,
  output var logic [15:0] idx,
  output var logic [7:0] sub,
  output var logic [31:0] wdata
);
  // ************************************************************
  // Access sequencing
  // ************************************************************
  // Idle at time zero
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    pdo = 1'b0;
    idx = 16'h0000;
    sub = 8'h00;
    wdata = 32'h0000_0000;
  end

  // One-cycle strobe; afterwards the lines carry junk so stale values are never trusted
  task automatic access(input logic w, input logic p, input logic [15:0] i,
                        input logic [7:0] s, input logic [31:0] d);
    @(posedge clk);
    #1;
    wr = w;
    rd = !w;
    pdo = p;
    idx = i;
    sub = s;
    wdata = d;
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
    idx = ~idx;
    sub = ~sub;
    wdata = ~wdata;
  endtask
endmodule // mpo_master
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the pulse output block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end

module tb;
  logic clk, rst_n, wr, rd, pdo;
  logic [15:0] idx;
  logic [7:0] sub;
  logic [31:0] wdata, seed, f, d, n;
  logic [3:0] trig, prev;
  wire [31:0] rdata;
  wire ack, err;
  wire [3:0] pulse, in_state;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int bad_count, checked, cycles;
  int rises[4], first[4], run[4], hi[4], cnt[4];

  mpo_top i_mpo_top (.CLK(clk), .RST_N(rst_n), .OD_WR(wr), .OD_RD(rd), .OD_PDO(pdo),
    .OD_INDEX(idx), .OD_SUBIDX(sub), .OD_WDATA(wdata), .TRIGGER_CAPABLE_INPUT(trig),
    .OD_RDATA(rdata), .OD_ACK(ack), .OD_ERR(err), .PULSE_OUT(pulse), .INPUT_STATE(in_state));
  mpo_master i_mpo_master (.clk(clk), .wr(wr), .rd(rd), .pdo(pdo), .idx(idx), .sub(sub),
    .wdata(wdata));

  // ************************************************************
  // Clock, monitor and helpers
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Scoreboard, edge counters and run limit
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
    if (ack === 1'b1) begin
      e = exp_q.pop_front();
      `CHK("od_err", e[32], err)
      if (e[33]) `CHK("od_rdata", e[31:0], rdata)
    end
    for (int k = 0; k < 4; k++) begin
      if (pulse[k] === 1'b1 && prev[k] === 1'b0) begin
        rises[k]++;
        if (first[k] == 0) first[k] = cycles;
      end
      if (pulse[k] === 1'b1) run[k]++;
      else if (run[k] != 0) begin
        hi[k] = run[k];
        run[k] = 0;
      end
    end
    prev = pulse;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Note the expected answer, then let the master issue the access
  task automatic acc(input logic w, input logic p, input logic [15:0] i, input logic [7:0] s,
                     input logic [31:0] v, input logic ee, input logic [31:0] r);
    exp_q.push_back({!w, ee, r});
    i_mpo_master.access(w, p, i, s, v);
  endtask

  task automatic put(input logic [15:0] i, input logic [7:0] s, input logic [31:0] v);
    acc(1'b1, 1'b0, i, s, v, 1'b0, 32'h0000_0000);
  endtask

  task automatic get(input logic [15:0] i, input logic [7:0] s, input logic [31:0] r);
    acc(1'b0, 1'b0, i, s, 32'h0000_0000, 1'b0, r);
  endtask

  task automatic bad(input logic p, input logic [15:0] i, input logic [7:0] s,
                     input logic [31:0] v);
    acc(1'b1, p, i, s, v, 1'b1, 32'h0000_0000);
  endtask

  // Counters are cleared before waiting; sampling lands after the edge's updates
  task automatic clr_wait(input int c);
    for (int k = 0; k < 4; k++) begin
      rises[k] = 0;
      first[k] = 0;
    end
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic stop_test();
    $display("Mismatches %0d of %0d checks", bad_count, checked);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    rst_n = 1'b0;
    trig = 4'h0;
    prev = 4'h0;
    seed = 32'hd399_456b;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    for (logic [15:0] i = 16'h3100; i < 16'h3106; i++) get(i, 8'h00, 32'h0000_0004);
    get(16'h3106, 8'h00, 32'h0000_0001);
    bad(1'b0, 16'h3101, 8'h00, 32'h0000_0005);
    bad(1'b0, 16'h3103, 8'h05, 32'h0000_0005);
    bad(1'b0, 16'h3106, 8'h02, 32'h0000_0001);
    bad(1'b0, 16'h3100, 8'h01, 32'h0000_0002);
    bad(1'b1, 16'h3101, 8'h01, 32'h0000_0001);
    acc(1'b1, 1'b1, 16'h3100, 8'h04, 32'h0000_0000, 1'b0, 32'h0000_0000);
    // Random settings stay inside the legal spans, then pulse settings: 250 cycle period
    for (int c = 1; c < 5; c++) begin
      f = 100 + rnd() % 4999901;
      d = 1 + rnd() % 999;
      n = 1 + rnd() % 65535;
      put(16'h3102, 8'(c), f);
      put(16'h3103, 8'(c), d);
      put(16'h3101, 8'(c), n);
      get(16'h3102, 8'(c), f);
      get(16'h3103, 8'(c), d);
      get(16'h3101, 8'(c), n);
      put(16'h3102, 8'(c), 32'h004C_4B40);
      put(16'h3103, 8'(c), 32'h0000_01F4);
      cnt[c - 1] = 1 + rnd() % 3;
      put(16'h3101, 8'(c), cnt[c - 1]);
    end
    // One burst per channel, only on the addressed output
    for (int c = 0; c < 4; c++) begin
      clr_wait(100);
      put(16'h3100, 8'(c + 1), 32'h0000_0001);
      clr_wait(900);
      `CHK("burst rises", cnt[c], rises[c])
      `CHK("other rises", 0, rises.sum() - rises[c])
      `CHK("high time", 125, hi[c])
      get(16'h3100, 8'(c + 1), 32'h0000_0000);
    end
    // Continuous mode ignores the burst count and stops on zero
    put(16'h2004, 8'h01, 32'h0000_0001);
    put(16'h3100, 8'h01, 32'h0000_0001);
    clr_wait(900);
    `CHK("cont rises", 4, rises[0])
    put(16'h3100, 8'h01, 32'h0000_0000);
    clr_wait(300);
    clr_wait(300);
    `CHK("stopped", 0, rises[0])
    `CHK("stopped level", 1'b0, pulse[0])
    // Second pin becomes a trigger and vanishes from the input view
    put(16'h3104, 8'h02, 32'h0000_0001);
    trig = 4'b0011;
    clr_wait(600);
    `CHK("input view", 4'b0001, in_state)
    `CHK("trig rises", 3, rises[1])
    trig = 4'b0000;
    clr_wait(300);
    clr_wait(300);
    `CHK("trig released", 0, rises[1])
    // Channels one and three start together, third at half the rate
    put(16'h3104, 8'h02, 32'h0000_0000);
    put(16'h3102, 8'h03, 32'h0026_25A0);
    for (int c = 0; c < 4; c++) put(16'h3105, 8'(c + 1), {31'h0, ~c[0]});
    // Two divider rounds must pass so the new period is ready before the start
    clr_wait(200);
    put(16'h3106, 8'h01, 32'h0000_0001);
    clr_wait(600);
    `CHK("aligned rise", first[0], first[2])
    `CHK("unselected", 0, rises[1] + rises[3])
    `CHK("own period a", 3, rises[0])
    `CHK("own period b", 2, rises[2])
    stop_test();
  end
endmodule // tb
`default_nettype wire
